//--- hub_port_power_defs.vh
`ifndef HUB_PORT_POWER_DEFS_VH
`define HUB_PORT_POWER_DEFS_VH

// Core clock rate in MHz.
`define CLK_MHZ 100
// Length of the configuration stage after reset release, in ns.
`define CFG_TIME_NS 100
// Configuration stage length in core clock cycles, rounded up.
`define CFG_CYCLES ((`CFG_TIME_NS * `CLK_MHZ + 999) / 1000)

// Register addresses.
`define DYN_PWR_ADDR 16'h4134
`define FIXED_CFG_ADDR 16'h4135
`define PORT_STATUS_ADDR 16'h4136

// Register reset values and the dynamic switching key.
`define DYN_PWR_RESET 8'hC1
`define DYN_PWR_ENABLE 8'h41
`define FIXED_CFG_RESET 8'h00

// Status register field positions.
`define ST_OC3_BIT 0
`define ST_OC4_BIT 1
`define ST_SELF_BIT 2
`define ST_CHG3_BIT 3
`define ST_CHG4_BIT 4
`define ST_DONE_BIT 5

`endif

//--- port_power_slice.v
`timescale 1ns/1ps

// One downstream port: strap capture, power pin drive and over-current handling.
module port_power_slice
(
  input wire core_clk,
  input wire srst,
  input wire combinedMode,
  input wire running,
  input wire sampleStrap,
  input wire powerReq,
  input wire ocClear,
  input wire pinIn,
  input wire senseLowIn,
  output wire pinOut,
  output wire pinOeN,
  output reg chargingEnable_q,
  output reg overcurrent_q,
  output reg supplyEnable_q
);

  // Two-stage synchronisers for the shared pin and the separate sense pin.
  reg pinMeta_q;
  reg pinSync_q;
  reg senseMeta_q;
  reg senseSync_q;
  // Supply history; a just-released shared pin still shows its old low level
  // for two synchroniser cycles, so it is only trusted once power has stood that long.
  reg supplyAge1_q;
  reg supplyAge2_q;
  // Over-current seen on whichever sense source the mode selects.
  wire ocSeen;

  // The first stage of each synchroniser feeds only the second stage.
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      pinMeta_q <= 1'b1;
      pinSync_q <= 1'b1;
      senseMeta_q <= 1'b1;
      senseSync_q <= 1'b1;
    end
    else
    begin
      pinMeta_q <= pinIn;
      pinSync_q <= pinMeta_q;
      senseMeta_q <= senseLowIn;
      senseSync_q <= senseMeta_q;
    end
  end

  // Age of the current supply grant, used to blank the shared-pin sense after release.
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      supplyAge1_q <= 1'b0;
      supplyAge2_q <= 1'b0;
    end
    else
    begin
      supplyAge1_q <= supplyEnable_q;
      supplyAge2_q <= supplyAge1_q;
    end
  end

  // In combined mode the pin is only a valid sense once it has settled after release.
  assign ocSeen = running & (combinedMode ? (supplyEnable_q & supplyAge1_q & supplyAge2_q & ~pinSync_q)
                                          : ~senseSync_q);

  // Charging strap is latched from the pin while it is still released.
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      chargingEnable_q <= 1'b0;
    end
    else if (sampleStrap)
    begin
      chargingEnable_q <= pinSync_q;
    end
  end

  // Sticky over-current flag; a new event wins over a clear in the same cycle.
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      overcurrent_q <= 1'b0;
    end
    else if (ocSeen)
    begin
      overcurrent_q <= 1'b1;
    end
    else if (ocClear)
    begin
      overcurrent_q <= 1'b0;
    end
  end

  // Power is granted only when running, requested and free of over-current.
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      supplyEnable_q <= 1'b0;
    end
    else
    begin
      supplyEnable_q <= running & powerReq & ~overcurrent_q & ~ocSeen;
    end
  end

  // Open-drain in combined mode: releasing the pin means power on.
  // Outside the running state the pin is released so the strap can be read.
  // Gated by the run state so power drops at the same edge the pin is released.
  assign pinOut = combinedMode ? 1'b0 : (supplyEnable_q & running);
  assign pinOeN = ~running | (combinedMode & supplyEnable_q);

endmodule

//--- hub_port_power_strap_latch.v
`timescale 1ns/1ps
`include "hub_port_power_defs.vh"

module hub_port_power_strap_latch
(
  input wire core_clk,
  input wire srst,
  input wire extResetN,
  input wire self_supply_detect,
  input wire selfSupplyInUse,
  input wire [1:0] fixed_device_straps,
  input wire port3_combined_control,
  input wire port4_combined_control,
  input wire port3PowerReq,
  input wire port4PowerReq,
  input wire port3PinIn,
  input wire port4PinIn,
  input wire port3_overcurrent_sense_low,
  input wire port4_overcurrent_sense_low,
  input wire [15:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  input wire otpWrite,
  input wire [15:0] otpAddr,
  input wire [7:0] otpData,
  output reg [7:0] regRdData,
  output wire port3_supply_enable,
  output wire port3PinOeN,
  output wire port4_supply_enable,
  output wire port4PinOeN,
  output wire port3ChargingEnable,
  output wire port4ChargingEnable,
  output wire port3Overcurrent,
  output wire port4Overcurrent,
  output reg selfPowered_q,
  output reg [1:0] fixedDevice_q,
  output wire configDone
);

  // One-hot states of the start-up sequence.
  localparam [2:0] ST_HOLD = 3'b001;
  localparam [2:0] ST_CONFIG = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;

  // External reset synchroniser.
  reg extMeta_q;
  reg extSync_q;
  // Self-supply detect synchroniser.
  reg selfMeta_q;
  reg selfSync_q;
  // Fixed-device strap synchroniser.
  reg [1:0] fixedMeta_q;
  reg [1:0] fixedSync_q;
  // Sequencer state and its next value.
  reg [2:0] state_q;
  reg [2:0] state_d;
  // Configuration stage cycle counter.
  reg [7:0] cfgCount_q;
  // Power-source value frozen at the end of configuration.
  reg selfLatched_q;
  // Registers reachable over SMBus or OTP.
  reg [7:0] dynamicPower_q;
  reg [7:0] fixedCfg_q;
  // Raw strap values, refreshed only in the configuration stage.
  reg [1:0] fixedStrapLatched_q;
  // Decoded controls.
  wire running;
  wire sampleStrap;
  wire dynamicMode;
  wire wrEn;
  wire [15:0] wrAddr;
  wire [7:0] wrData;
  wire oc3Clear;
  wire oc4Clear;

  // External reset, self-supply detect and fixed-device strap pins are synchronised before any logic reads them.
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      extMeta_q <= 1'b0;
      extSync_q <= 1'b0;
      selfMeta_q <= 1'b0;
      selfSync_q <= 1'b0;
      fixedMeta_q <= 2'h0;
      fixedSync_q <= 2'h0;
    end
    else
    begin
      extMeta_q <= extResetN;
      extSync_q <= extMeta_q;
      selfMeta_q <= self_supply_detect;
      selfSync_q <= selfMeta_q;
      fixedMeta_q <= fixed_device_straps;
      fixedSync_q <= fixedMeta_q;
    end
  end

  // Next-state logic of the start-up sequencer.
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_HOLD:
      begin
        // Wait here while the external reset holds the device in standby.
        if (extSync_q)
        begin
          state_d = ST_CONFIG;
        end
      end
      ST_CONFIG:
      begin
        if (!extSync_q)
        begin
          state_d = ST_HOLD;
        end
        else if (cfgCount_q == `CFG_CYCLES - 1)
        begin
          state_d = ST_RUN;
        end
      end
      ST_RUN:
      begin
        // A new external reset drops push-pull port power at once and releases combined-mode pins.
        if (!extSync_q)
        begin
          state_d = ST_HOLD;
        end
      end
      default:
      begin
        state_d = ST_HOLD;
      end
    endcase
  end

  // Sequencer state and configuration counter.
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      state_q <= ST_HOLD;
      cfgCount_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == ST_CONFIG)
      begin
        cfgCount_q <= cfgCount_q + 8'h01;
      end
      else
      begin
        cfgCount_q <= 8'h00;
      end
    end
  end

  assign running = (state_q == ST_RUN);
  assign configDone = running;
  // Straps are taken on the last configuration cycle, after power-on or ext reset rise.
  assign sampleStrap = (state_q == ST_CONFIG) && (state_d == ST_RUN);

  // Power-source latch; it only changes while configuring.
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      selfLatched_q <= 1'b0;
      fixedStrapLatched_q <= 2'h0;
    end
    else if (sampleStrap)
    begin
      selfLatched_q <= selfSync_q;
      fixedStrapLatched_q <= fixedSync_q;
    end
  end

  // Dynamic switching needs the exact key; any other value keeps the latch.
  assign dynamicMode = (dynamicPower_q == `DYN_PWR_ENABLE);

  // Power source and non-removable state seen by the rest of the hub.
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      selfPowered_q <= 1'b0;
      fixedDevice_q <= 2'h0;
    end
    else
    begin
      selfPowered_q <= (dynamicMode && running) ? selfSync_q : selfLatched_q;
      fixedDevice_q <= selfSupplyInUse ? fixedCfg_q[1:0] : fixedStrapLatched_q;
    end
  end

  // OTP loads take priority; they happen during start-up when SMBus is idle.
  assign wrEn = otpWrite | regWrite;
  assign wrAddr = otpWrite ? otpAddr : regAddr;
  assign wrData = otpWrite ? otpData : regWrData;
  // Status writes clear over-current flags where a one is written.
  assign oc3Clear = wrEn && (wrAddr == `PORT_STATUS_ADDR) && wrData[`ST_OC3_BIT];
  assign oc4Clear = wrEn && (wrAddr == `PORT_STATUS_ADDR) && wrData[`ST_OC4_BIT];

  // Writable configuration registers; unmapped writes are dropped.
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      dynamicPower_q <= `DYN_PWR_RESET;
      fixedCfg_q <= `FIXED_CFG_RESET;
    end
    else if (wrEn)
    begin
      if (wrAddr == `DYN_PWR_ADDR)
      begin
        dynamicPower_q <= wrData;
      end
      if (wrAddr == `FIXED_CFG_ADDR)
      begin
        fixedCfg_q <= {6'h00, wrData[1:0]};
      end
    end
  end

  // Registered read data; unmapped addresses read as zero.
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      regRdData <= 8'h00;
    end
    else if (regRead)
    begin
      case (regAddr)
        `DYN_PWR_ADDR: regRdData <= dynamicPower_q;
        `FIXED_CFG_ADDR: regRdData <= fixedCfg_q;
        `PORT_STATUS_ADDR: regRdData <= {2'h0, running, port4ChargingEnable, port3ChargingEnable,
                                         selfPowered_q, port4Overcurrent, port3Overcurrent};
        default: regRdData <= 8'h00;
      endcase
    end
  end

  // Port 3 power, strap and over-current handling.
  port_power_slice port3Slice
  (
    .core_clk(core_clk),
    .srst(srst),
    .combinedMode(port3_combined_control),
    .running(running),
    .sampleStrap(sampleStrap),
    .powerReq(port3PowerReq),
    .ocClear(oc3Clear),
    .pinIn(port3PinIn),
    .senseLowIn(port3_overcurrent_sense_low),
    .pinOut(port3_supply_enable),
    .pinOeN(port3PinOeN),
    .chargingEnable_q(port3ChargingEnable),
    .overcurrent_q(port3Overcurrent),
    .supplyEnable_q()
  );

  // Port 4 power, strap and over-current handling.
  port_power_slice port4Slice
  (
    .core_clk(core_clk),
    .srst(srst),
    .combinedMode(port4_combined_control),
    .running(running),
    .sampleStrap(sampleStrap),
    .powerReq(port4PowerReq),
    .ocClear(oc4Clear),
    .pinIn(port4PinIn),
    .senseLowIn(port4_overcurrent_sense_low),
    .pinOut(port4_supply_enable),
    .pinOeN(port4PinOeN),
    .chargingEnable_q(port4ChargingEnable),
    .overcurrent_q(port4Overcurrent),
    .supplyEnable_q()
  );

endmodule

//--- hub_pwr_chk.sv
`timescale 1ns/1ps

// Watches port 3 power, configuration timing and the read port.
module hub_pwr_chk
(
  input wire core_clk,
  input wire srst,
  input wire extResetN,
  input wire port3_combined_control,
  input wire port3_overcurrent_sense_low,
  input wire [15:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  input wire otpWrite,
  input wire [7:0] regRdData,
  input wire port3_supply_enable,
  input wire port3PinOeN,
  input wire port3Overcurrent,
  input wire configDone
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  a_hold_no_power: assert property ((!extResetN)[*5] |-> !configDone && !port3_supply_enable)
    else $error("power or run state kept in external reset");
  a_idle_no_power: assert property ((!configDone)[*2] |-> !port3_supply_enable)
    else $error("port power outside run state");
  a_oc_blocks_pwr: assert property (port3_supply_enable |-> !port3Overcurrent)
    else $error("port power with over-current flag set");
  a_push_pull_drive: assert property (!port3_combined_control && port3_supply_enable |-> !port3PinOeN)
    else $error("power pin not driven while on");
  a_open_drain_low: assert property (port3_combined_control |-> !port3_supply_enable)
    else $error("shared pin driven high");
  a_oc_flag_set: assert property
    ((configDone && !port3_combined_control && !port3_overcurrent_sense_low)[*3] |=> port3Overcurrent)
    else $error("over-current not flagged");
  a_oc_flag_sticky: assert property (port3Overcurrent && configDone && !otpWrite &&
    !(regWrite && regAddr == 16'h4136 && regWrData[0]) |=> port3Overcurrent || !configDone)
    else $error("over-current flag lost");
  a_rd_data_hold: assert property (!regRead |=> $stable(regRdData))
    else $error("read data changed without read");
  a_unmapped_zero: assert property (regRead && regAddr == 16'h0000 |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_cfg_after_rise: assert property ($rose(extResetN) |-> (!configDone)[*8] ##[4:8] configDone)
    else $error("configuration timing wrong");
endmodule

bind hub_port_power_strap_latch hub_pwr_chk chk (.core_clk(core_clk), .srst(srst), .extResetN(extResetN),
  .port3_combined_control(port3_combined_control), .port3_overcurrent_sense_low(port3_overcurrent_sense_low),
  .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .otpWrite(otpWrite),
  .regRdData(regRdData), .port3_supply_enable(port3_supply_enable), .port3PinOeN(port3PinOeN),
  .port3Overcurrent(port3Overcurrent), .configDone(configDone));

//--- board_model.sv
`timescale 1ns/1ps

// Board side of ports 3 and 4: strap resistors, shared pins and power switches.
module board_model
(
  input wire p3Out,
  input wire p3OeN,
  input wire p4Out,
  input wire p4OeN,
  input wire [1:0] strapLvl,
  input wire [1:0] fault,
  output wire p3Pin,
  output wire p4Pin,
  output wire [1:0] senseLow
);
  // A released pin settles to its strap resistor; a tripped switch pulls it low.
  assign p3Pin = !p3OeN ? p3Out : (!fault[0] && strapLvl[0]);
  assign p4Pin = !p4OeN ? p4Out : (!fault[1] && strapLvl[1]);
  // Separate sense lines idle high through pull-ups and drop on a trip.
  assign senseLow = ~fault;
endmodule

//--- tb.sv
`timescale 1ns/1ps
`include "hub_port_power_defs.vh"

module tb;
  logic core_clk = 0, srst = 1, extResetN = 1, selfDet = 1, selfUse = 0;
  logic regWrite = 0, regRead = 0, otpWrite = 0, rdPend = 0;
  logic [1:0] fixStr = 2'b10, strap = 2'b11, fault = 2'b00, comb = 2'b10, req = 2'b00;
  logic [15:0] regAddr = 16'h0000, otpAddr = 16'h0000;
  logic [7:0] wrData = 8'h00, otpData = 8'h00;
  logic [7:0] expQ[$];
  wire [7:0] rdData;
  wire [1:0] sense, fixDev;
  wire p3Out, p3OeN, p4Out, p4OeN, p3Pin, p4Pin, chg3, chg4, oc3, oc4, selfP, done;
  int errors = 0, total_checks = 0, r, i;

  hub_port_power_strap_latch uut (.core_clk(core_clk), .srst(srst), .extResetN(extResetN),
    .self_supply_detect(selfDet), .selfSupplyInUse(selfUse), .fixed_device_straps(fixStr),
    .port3_combined_control(comb[0]), .port4_combined_control(comb[1]), .port3PowerReq(req[0]),
    .port4PowerReq(req[1]), .port3PinIn(p3Pin), .port4PinIn(p4Pin), .port3_overcurrent_sense_low(sense[0]),
    .port4_overcurrent_sense_low(sense[1]), .regAddr(regAddr), .regWrData(wrData), .regWrite(regWrite),
    .regRead(regRead), .otpWrite(otpWrite), .otpAddr(otpAddr), .otpData(otpData), .regRdData(rdData),
    .port3_supply_enable(p3Out), .port3PinOeN(p3OeN), .port4_supply_enable(p4Out), .port4PinOeN(p4OeN),
    .port3ChargingEnable(chg3), .port4ChargingEnable(chg4), .port3Overcurrent(oc3), .port4Overcurrent(oc4),
    .selfPowered_q(selfP), .fixedDevice_q(fixDev), .configDone(done));
  board_model brd (.p3Out(p3Out), .p3OeN(p3OeN), .p4Out(p4Out), .p4OeN(p4OeN), .strapLvl(strap),
    .fault(fault), .p3Pin(p3Pin), .p4Pin(p4Pin), .senseLow(sense));

  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  task check(input [7:0] seen, input [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Expected status byte, laid out by the header's field positions.
  function [7:0] st(input o3, input o4, input sp, input c3, input c4, input d);
    st = 8'h00;
    st[`ST_OC3_BIT] = o3;
    st[`ST_OC4_BIT] = o4;
    st[`ST_SELF_BIT] = sp;
    st[`ST_CHG3_BIT] = c3;
    st[`ST_CHG4_BIT] = c4;
    st[`ST_DONE_BIT] = d;
  endfunction

  // A read notes its expected byte; the monitor compares when the data lands.
  task rd(input [15:0] a, input [7:0] e);
    @(negedge core_clk);
    regAddr = a;
    regRead = 1;
    expQ.push_back(e);
    @(negedge core_clk);
    regRead = 0;
  endtask

  // Bus write, with an optional OTP load of another value in the same cycle.
  task wr(input [15:0] a, input [7:0] d, input o, input [7:0] od);
    @(negedge core_clk);
    regAddr = a;
    wrData = d;
    regWrite = 1;
    otpAddr = a;
    otpData = od;
    otpWrite = o;
    @(negedge core_clk);
    regWrite = 0;
    otpWrite = 0;
  endtask

  // Bounded wait for the run state, then time for the supply flag to land.
  task wait_done;
    int n;
    n = 0;
    while (done !== 1'b1 && n < 50)
    begin
      @(negedge core_clk);
      n++;
    end
    if (done !== 1'b1)
    begin
      errors++;
      end_of_test;
    end
    repeat (3) @(negedge core_clk);
  endtask

  // Pulse the external reset long enough to pass its synchroniser.
  task ext_reset;
    @(negedge core_clk);
    extResetN = 0;
    repeat (6) @(negedge core_clk);
    check({7'h00, done}, 8'h00);
    extResetN = 1;
    wait_done;
  endtask

  always @(posedge core_clk) rdPend <= regRead;

  // Oldest note against the read data, on the falling edge half a cycle after the read edge.
  always @(negedge core_clk)
    if (rdPend && expQ.size() > 0)
      check(rdData, expQ.pop_front());

  initial
  begin
    r = $urandom(48);
    repeat (10) @(negedge core_clk);
    srst = 0;
    rd(`DYN_PWR_ADDR, `DYN_PWR_RESET);
    rd(`FIXED_CFG_ADDR, `FIXED_CFG_RESET);
    rd(16'h0000, 8'h00);
    wait_done;
    rd(`PORT_STATUS_ADDR, st(0, 0, 1, 1, 1, 1));
    check({6'h00, fixDev}, 8'h02);
    // Later input changes must not move the latched values.
    selfDet = 0;
    fixStr = 2'b01;
    repeat (5) @(negedge core_clk);
    check({4'h0, fixDev, 1'b0, selfP}, 8'h09);
    wr(`FIXED_CFG_ADDR, 8'hFD, 0, 8'h00);
    rd(`FIXED_CFG_ADDR, 8'h01);
    // Every supply and strap-use combination with random strap levels.
    for (i = 0; i < 4; i++)
    begin
      selfDet = i[0];
      selfUse = i[1];
      r = $urandom;
      strap = r[1:0];
      fixStr = r[3:2];
      ext_reset;
      rd(`PORT_STATUS_ADDR, st(0, 0, i[0], strap[0], strap[1], 1));
      check({6'h00, chg4, chg3}, {6'h00, strap});
      check({6'h00, fixDev}, {6'h00, i[1] ? 2'b01 : fixStr});
    end
    // Dynamic switching follows the input only under the enable key.
    wr(`DYN_PWR_ADDR, `DYN_PWR_ENABLE, 0, 8'h00);
    rd(`DYN_PWR_ADDR, `DYN_PWR_ENABLE);
    selfDet = 0;
    repeat (5) @(negedge core_clk);
    check({7'h00, selfP}, 8'h00);
    // An OTP load in the same cycle wins; the latched self-powered value returns.
    wr(`DYN_PWR_ADDR, `DYN_PWR_ENABLE, 1, `DYN_PWR_RESET);
    rd(`DYN_PWR_ADDR, `DYN_PWR_RESET);
    repeat (5) @(negedge core_clk);
    check({7'h00, selfP}, 8'h01);
    // Port power, over-current trip on both pin styles, then clear.
    strap = 2'b11;
    selfDet = 1;
    ext_reset;
    req = 2'b11;
    repeat (3) @(negedge core_clk);
    check({4'h0, p3Out, p3OeN, p4Out, p4OeN}, 8'h09);
    fault = 2'b11;
    repeat (6) @(negedge core_clk);
    check({5'h00, p3Out, p4Out, p4OeN}, 8'h00);
    check({6'h00, oc4, oc3}, 8'h03);
    fault = 2'b00;
    rd(`PORT_STATUS_ADDR, st(1, 1, 1, 1, 1, 1));
    wr(`PORT_STATUS_ADDR, 8'h01, 0, 8'h00);
    rd(`PORT_STATUS_ADDR, st(0, 1, 1, 1, 1, 1));
    check({7'h00, p3Out}, 8'h01);
    wr(`PORT_STATUS_ADDR, 8'h02, 0, 8'h00);
    repeat (3) @(negedge core_clk);
    check({6'h00, p4Out, p4OeN}, 8'h01);
    // A second power-on reset in mid-run keeps the register at its default.
    srst = 1;
    @(negedge core_clk);
    srst = 0;
    rd(`DYN_PWR_ADDR, `DYN_PWR_RESET);
    repeat (2) @(negedge core_clk);
    end_of_test;
  end
endmodule
